// ===== mcsp_host_port.sv
// Operation
// - every frame is exactly 32 bits
// - shift input on serial clock rise
// - select rise copies frame to buffer
// - return bit driven within four clocks
// - asynchronous inputs resolved by sampling
// - deselected output shows interrupt level
// - data valid at rise, no period limit
// - most significant bit first both ways
// - return 32-bit frame while receiving
// - status upper 8, read data lower 24
// - read flag one reads, zero writes
// - select flag steers registers or RAM
// - read frames ignore data bits
// - reset clears all, pre-divider to 15
// - ignore frames until reset complete
// - multiplexed output always actively driven
// - tri-state output, interrupt-only pin mode
// - select flag bit 31, address 30..25
// - status byte carries interrupt and flags
`timescale 1ns/100ps
`default_nettype none

module mcsp_host_port (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // Host serial pins
   input wire logic host_sclk_i,
   input wire logic host_select_n_i,
   input wire logic host_sdi_i,
   output logic irq_or_serial_out_pin_o,
   output logic host_serial_out_tristate_o,
   output logic host_serial_out_tristate_oe_o,
   // Pin mode and status sources
   input wire logic irq_only_i,
   input wire logic interrupt_n_i,
   input wire logic cover_frame_waiting_i,
   input wire logic [2:0] ref_left_i,
   input wire logic [2:0] target_reached_i,
   // Read port into the register set and RAM
   output logic rd_req_o,
   output logic rd_ram_sel_o,
   output logic [5:0] rd_addr_o,
   input wire logic [23:0] rd_data_i,
   // Latched frame and write strobe
   output mcsp_pkg::mcsp_frame_t frame_o,
   output logic frame_valid_o,
   output logic wr_strobe_o,
   output logic frame_len_err_o,
   output logic frame_active_o,
   output logic [3:0] chain_clock_prediv_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [1:0] rst_pipe_ff;
   logic rst_n;
   logic [2:0] sclk_sync_ff;
   logic [2:0] sel_sync_ff;
   logic [1:0] sdi_sync_ff;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_fall;
   logic sel_rise;
   logic sdi_bit;
   mcsp_pkg::mcsp_state_t state_ff;
   mcsp_pkg::mcsp_state_t nxt_state;
   logic [31:0] rx_shift_ff;
   logic [31:0] nxt_rx_shift;
   logic [5:0] rx_cnt_ff;
   logic [31:0] tx_ff;
   logic [4:0] tx_ptr_ff;
   logic [4:0] nxt_tx_ptr;
   logic rd_req_ff;
   logic rd_take_ff;
   logic [6:0] rd_hdr_ff;
   logic in_frame;
   logic mux_pin_ff;
   logic tri_data_ff;
   logic tri_oe_ff;
   mcsp_pkg::mcsp_frame_t frame_ff;
   mcsp_pkg::mcsp_frame_t rx_frame;
   mcsp_pkg::mcsp_status_t status;
   logic frame_valid_ff;
   logic wr_strobe_ff;
   logic len_err_ff;
   logic [3:0] prediv_ff;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // Asserts at once, releases two clocks later on a clean edge
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_pipe_ff <= 2'h0;
      end else begin
         rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe_ff[1];

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Host pins bear no phase relation to sys_clk; stage 0 is only
   // read by stage 1, and edges are taken from stages 1 and 2
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sclk_sync_ff <= mcsp_pkg::SYNC_IDLE_HI;
         sel_sync_ff <= mcsp_pkg::SYNC_IDLE_HI;
         sdi_sync_ff <= mcsp_pkg::SYNC_IDLE_LO[1:0];
      end else begin
         sclk_sync_ff <= {sclk_sync_ff[1:0], host_sclk_i};
         sel_sync_ff <= {sel_sync_ff[1:0], host_select_n_i};
         sdi_sync_ff <= {sdi_sync_ff[0], host_sdi_i};
      end
   end

   // Edge strobes, one cycle each
   assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
   assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
   assign sel_fall = ~sel_sync_ff[1] & sel_sync_ff[2];
   assign sel_rise = sel_sync_ff[1] & ~sel_sync_ff[2];
   // Data is sampled alongside the clock so the relative skew of the
   // two lines stays within one sys_clk period
   assign sdi_bit = sdi_sync_ff[1];

   // ----------------------------------------------------------------
   // Frame controller
   // ----------------------------------------------------------------
   // After reset the port waits for select to be seen high, but the synchronisers reset
   // high, so a frame already running at release is received from its remaining bits
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         mcsp_pkg::ST_BLOCKED: begin
            if (sel_sync_ff[1]) begin
               nxt_state = mcsp_pkg::ST_IDLE;
            end
         end
         mcsp_pkg::ST_IDLE: begin
            if (sel_fall) begin
               nxt_state = mcsp_pkg::ST_FRAME;
            end
         end
         mcsp_pkg::ST_FRAME: begin
            if (sel_rise) begin
               nxt_state = mcsp_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = mcsp_pkg::ST_BLOCKED;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= mcsp_pkg::ST_BLOCKED;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign in_frame = (state_ff == mcsp_pkg::ST_FRAME);

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   // Most significant bit arrives first and ends up in bit 31
   assign nxt_rx_shift = {rx_shift_ff[30:0], sdi_bit};
   assign rx_frame = rx_shift_ff;

   // Shift on each synced clock rise; no timeout, so an arbitrarily
   // slow host clock is fine
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rx_shift_ff <= '0;
         rx_cnt_ff <= '0;
      end else if (sel_fall && state_ff == mcsp_pkg::ST_IDLE) begin
         rx_cnt_ff <= '0;
      end else if (in_frame && sclk_rise) begin
         rx_shift_ff <= nxt_rx_shift;
         if (rx_cnt_ff != mcsp_pkg::RX_CNT_MAX) begin
            rx_cnt_ff <= rx_cnt_ff + 6'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Early read request
   // ----------------------------------------------------------------
   // Once the header byte is in, the read is issued so that the data
   // is ready well before the 24 data bits start going out
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_req_ff <= 1'b0;
         rd_take_ff <= 1'b0;
         rd_hdr_ff <= '0;
      end else begin
         rd_req_ff <= 1'b0;
         rd_take_ff <= rd_req_ff;
         if (in_frame && sclk_rise && rx_cnt_ff == mcsp_pkg::RX_HDR_LAST) begin
            rd_req_ff <= sdi_bit;
            rd_hdr_ff <= rx_shift_ff[6:0];
         end
      end
   end

   // Bit 6 of the header is the space select, bits 5..0 the address
   assign rd_req_o = rd_req_ff;
   assign rd_ram_sel_o = rd_hdr_ff[6];
   assign rd_addr_o = rd_hdr_ff[5:0];

   // ----------------------------------------------------------------
   // Return frame
   // ----------------------------------------------------------------
   // Status snapshot taken as select falls; the interrupt flag is the
   // active-high view of the internal active-low line
   always_comb begin
      status.irq = ~interrupt_n_i;
      status.cover_frame_waiting = cover_frame_waiting_i;
      status.ref_left = ref_left_i;
      status.target_reached = target_reached_i;
   end

   // Pointer steps down on each synced clock fall after the first and
   // stops at 0. Bit 31 already stands from the select fall, so the
   // first fall keeps it: stepping there would hand the host bit 30
   // at its first rising edge and the top bit would be lost
   always_comb begin
      nxt_tx_ptr = tx_ptr_ff;
      if (in_frame && sclk_fall && tx_ptr_ff != 5'h00 &&
          rx_cnt_ff != 6'h00) begin
         nxt_tx_ptr = tx_ptr_ff - 5'h01;
      end
   end

   // Write frames return zeros below the status byte
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_ff <= '0;
         tx_ptr_ff <= mcsp_pkg::TX_FIRST;
      end else if (sel_fall && state_ff == mcsp_pkg::ST_IDLE) begin
         tx_ff <= {status, mcsp_pkg::DATA_ZERO};
         tx_ptr_ff <= mcsp_pkg::TX_FIRST;
      end else begin
         tx_ptr_ff <= nxt_tx_ptr;
         if (rd_take_ff) begin
            tx_ff[23:0] <= rd_data_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // Output pins
   // ----------------------------------------------------------------
   // The pin flop reads the next pointer so a return bit follows the
   // clock fall by three sys_clk edges: two sync stages plus this one
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mux_pin_ff <= 1'b1;
         tri_data_ff <= 1'b0;
         tri_oe_ff <= 1'b0;
      end else begin
         tri_data_ff <= tx_ff[nxt_tx_ptr];
         tri_oe_ff <= in_frame && !sel_rise;
         if (in_frame && !sel_rise && !irq_only_i) begin
            mux_pin_ff <= tx_ff[nxt_tx_ptr];
         end else begin
            mux_pin_ff <= interrupt_n_i;
         end
      end
   end

   // Multiplexed pin is a plain push-pull output, never released
   assign irq_or_serial_out_pin_o = mux_pin_ff;
   assign host_serial_out_tristate_o = tri_data_ff;
   assign host_serial_out_tristate_oe_o = tri_oe_ff;

   // ----------------------------------------------------------------
   // Frame latch and write strobe
   // ----------------------------------------------------------------
   // Only a frame of exactly 32 clock rises is taken; anything else is
   // flagged and dropped so a glitched frame cannot corrupt a register
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         frame_ff <= '0;
         frame_valid_ff <= 1'b0;
         wr_strobe_ff <= 1'b0;
         len_err_ff <= 1'b0;
      end else begin
         frame_valid_ff <= 1'b0;
         wr_strobe_ff <= 1'b0;
         len_err_ff <= 1'b0;
         if (in_frame && sel_rise) begin
            if (rx_cnt_ff == mcsp_pkg::RX_FULL_CNT) begin
               frame_ff <= rx_frame;
               frame_valid_ff <= 1'b1;
               wr_strobe_ff <= !rx_frame.read;
            end else begin
               len_err_ff <= 1'b1;
            end
         end
      end
   end

   assign frame_o = frame_ff;
   assign frame_valid_o = frame_valid_ff;
   assign wr_strobe_o = wr_strobe_ff;
   assign frame_len_err_o = len_err_ff;
   assign frame_active_o = in_frame;

   // ----------------------------------------------------------------
   // Driver-chain clock pre-divider
   // ----------------------------------------------------------------
   // Held here because it is the one field that does not reset to 0;
   // a read frame leaves it untouched whatever its data bits say
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prediv_ff <= mcsp_pkg::PREDIV_RST;
      end else if (in_frame && sel_rise &&
                   rx_cnt_ff == mcsp_pkg::RX_FULL_CNT &&
                   !rx_frame.read && !rx_frame.ram_sel &&
                   rx_frame.addr == mcsp_pkg::GLOBAL_ADDR) begin
         prediv_ff <= rx_frame.data[3:0];
      end
   end

   assign chain_clock_prediv_o = prediv_ff;

endmodule
`default_nettype wire

// ===== mcsp_pkg.sv
`default_nettype none
package mcsp_pkg;

   // ----------------------------------------------------------------
   // Frame geometry
   // ----------------------------------------------------------------
   // Bit count of a complete frame, as the receive counter sees it
   localparam logic [5:0] RX_FULL_CNT = 6'h20;
   // Receive count at which the header byte is about to complete
   localparam logic [5:0] RX_HDR_LAST = 6'h07;
   // Receive counter saturates here so long frames stay long
   localparam logic [5:0] RX_CNT_MAX = 6'h3f;
   // Transmit pointer for the first (most significant) bit
   localparam logic [4:0] TX_FIRST = 5'h1f;

   // ----------------------------------------------------------------
   // Reset values and decoded locations
   // ----------------------------------------------------------------
   // Synchroniser reset values: serial clock and select idle high
   localparam logic [2:0] SYNC_IDLE_HI = 3'h7;
   localparam logic [2:0] SYNC_IDLE_LO = 3'h0;
   // Driver-chain clock pre-divider starts at its slowest setting
   localparam logic [3:0] PREDIV_RST = 4'hf;
   // Global parameter register that holds the pre-divider
   localparam logic [5:0] GLOBAL_ADDR = 6'h3f;
   // Read data is not meaningful for a write, data field reads 0
   localparam logic [23:0] DATA_ZERO = 24'h000000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Received frame, most significant field first on the wire
   typedef struct packed {
      logic ram_sel;     // 1 selects the on-chip RAM, 0 the registers
      logic [5:0] addr;  // Index within the chosen space
      logic read;        // 1 read, 0 write
      logic [23:0] data; // Write data, ignored for a read
   } mcsp_frame_t;

   // Status byte returned ahead of the read data
   typedef struct packed {
      logic irq;                  // Interrupt pending, active high
      logic cover_frame_waiting;  // Cover frame handshake
      logic [2:0] ref_left;       // Left reference switches 3..1
      logic [2:0] target_reached; // Per motor target reached 3..1
   } mcsp_status_t;

   // Port controller states
   typedef enum logic [1:0] {
      ST_BLOCKED,
      ST_IDLE,
      ST_FRAME
   } mcsp_state_t;

endpackage
`default_nettype wire

// ===== mcsp_host_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// Host port checker
// ------------------------------------------------
module mcsp_host_sva (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic host_select_n_i,
   input wire logic irq_only_i,
   input wire logic interrupt_n_i,
   input wire logic irq_or_serial_out_pin_o,
   input wire logic host_serial_out_tristate_oe_o,
   input wire logic frame_active_o,
   input wire logic rd_req_o,
   input wire mcsp_pkg::mcsp_frame_t frame_o,
   input wire logic frame_valid_o,
   input wire logic wr_strobe_o,
   input wire logic frame_len_err_o,
   input wire logic [3:0] chain_clock_prediv_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Latch only once select has risen and settled
   chk_latch_after_sel: assert property (
      frame_valid_o |-> host_select_n_i && $past(host_select_n_i, 2))
      else $error("latch without select rise");
   // Long deselect: the pin mirrors the interrupt
   chk_idle_irq_pin: assert property (
      host_select_n_i [*8] |=>
      irq_or_serial_out_pin_o == $past(interrupt_n_i))
      else $error("idle pin differs from interrupt");
   chk_irq_only_pin: assert property (
      irq_only_i && $past(irq_only_i) |->
      irq_or_serial_out_pin_o == $past(interrupt_n_i))
      else $error("interrupt-only pin differs");
   chk_oe_idle_low: assert property (
      host_select_n_i [*8] |=> !host_serial_out_tristate_oe_o)
      else $error("tristate driven while idle");
   chk_oe_in_frame: assert property (
      $fell(host_select_n_i) |-> ##[3:6] host_serial_out_tristate_oe_o)
      else $error("no return data driven");
   chk_wr_with_latch: assert property (
      wr_strobe_o |-> frame_valid_o && !frame_o.read)
      else $error("write strobe without write frame");
   chk_len_no_latch: assert property (
      frame_len_err_o |-> !frame_valid_o && !wr_strobe_o)
      else $error("bad length frame was latched");
   chk_rd_once: assert property (
      rd_req_o |-> frame_active_o ##1 (!rd_req_o) [*8])
      else $error("read request outside frame");
   chk_prediv_load: assert property (
      wr_strobe_o && !frame_o.ram_sel &&
      frame_o.addr == mcsp_pkg::GLOBAL_ADDR |->
      ##[0:2] chain_clock_prediv_o == frame_o.data[3:0])
      else $error("pre-divider not loaded");
   // Only a write may move the pre-divider
   chk_prediv_steady: assert property (
      $changed(chain_clock_prediv_o) |->
      wr_strobe_o || $past(wr_strobe_o) || $past(wr_strobe_o, 2))
      else $error("pre-divider changed alone");
endmodule

bind mcsp_host_port mcsp_host_sva u_chk (.sys_clk_i, .arst_n_i,
   .host_select_n_i, .irq_only_i, .interrupt_n_i, .irq_or_serial_out_pin_o,
   .host_serial_out_tristate_oe_o, .frame_active_o, .rd_req_o, .frame_o,
   .frame_valid_o, .wr_strobe_o, .frame_len_err_o, .chain_clock_prediv_o);
`default_nettype wire

// ===== mcsp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// Serial master model
// ------------------------------------------------
module mcsp_host_model (
   input wire logic sys_clk_i,
   input wire logic sdo_i,
   input wire logic sdoz_i,
   input wire logic oe_i,
   output logic sclk_o,
   output logic select_n_o,
   output logic sdi_o
);
   // Frame seen on the tri-state pin; unknown where it was not driven
   logic [31:0] rx_tri;
   // Idle bus: select and clock high
   initial begin
      sclk_o = 1'b1;
      select_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   // One frame, MSB first; half sets each clock phase in cycles
   task automatic xfer(input logic [31:0] tx, input int nbits,
                       input int half, output logic [31:0] rx);
      int i;
      rx = 32'h0;
      rx_tri = 32'h0;
      repeat (4) @(posedge sys_clk_i);
      select_n_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      for (i = nbits - 1; i >= 0; i--) begin
         sclk_o <= 1'b0;
         sdi_o <= (i < 32) ? tx[i] : 1'b0;
         repeat (half) @(posedge sys_clk_i);
         sclk_o <= 1'b1;
         rx = {rx[30:0], sdo_i};
         rx_tri = {rx_tri[30:0], oe_i ? sdoz_i : 1'bx};
         repeat (half) @(posedge sys_clk_i);
      end
      // No pull on data: show a changed level once released
      select_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
      // Long enough for the latch pulses to be counted before return
      repeat (6) @(posedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic sys_clk_i = 1'b0;
   logic arst_n_i, irq_only_i, interrupt_n_i, cfw, sclk, sel_n, sdi;
   logic pin, tz, toe, rd_req, rd_ram, fv, wr, le, act;
   logic [5:0] rd_addr;
   logic [23:0] rd_data = 24'h0;
   logic [3:0] prediv;
   logic [2:0] ref_l, teq;
   logic [31:0] rx;
   mcsp_pkg::mcsp_frame_t frame, last_frame;
   int err_total, tests_run, n_fv, n_wr, n_le, cyc;
   localparam int HALF = 8;
   localparam logic [7:0] STAT = {1'b1, 1'b1, 3'h2, 3'h5};

   always #25 sys_clk_i = ~sys_clk_i;

   mcsp_host_port u_dut (.sys_clk_i, .arst_n_i, .host_sclk_i(sclk),
      .host_select_n_i(sel_n), .host_sdi_i(sdi),
      .irq_or_serial_out_pin_o(pin), .host_serial_out_tristate_o(tz),
      .host_serial_out_tristate_oe_o(toe), .irq_only_i, .interrupt_n_i,
      .cover_frame_waiting_i(cfw), .ref_left_i(ref_l),
      .target_reached_i(teq), .rd_req_o(rd_req), .rd_ram_sel_o(rd_ram),
      .rd_addr_o(rd_addr), .rd_data_i(rd_data), .frame_o(frame),
      .frame_valid_o(fv), .wr_strobe_o(wr), .frame_len_err_o(le),
      .frame_active_o(act), .chain_clock_prediv_o(prediv));

   mcsp_host_model u_host (.sys_clk_i, .sdo_i(pin), .sdoz_i(tz),
      .oe_i(toe), .sclk_o(sclk), .select_n_o(sel_n), .sdi_o(sdi));

   // Register file stand-in answers one cycle after the request
   always @(posedge sys_clk_i)
      if (rd_req === 1'b1) rd_data <= {rd_ram, rd_addr, 17'h0abcd};

   // Pulse counters and hang guard
   always @(posedge sys_clk_i) begin
      cyc++;
      if (fv === 1'b1) begin
         n_fv++;
         last_frame = frame;
      end
      if (wr === 1'b1) n_wr++;
      if (le === 1'b1) n_le++;
      if (cyc == 20000) begin
         err_total++;
         $display("wrong value at %0t: timeout", $time);
         complete_run();
      end
   end

   task automatic cmp(input logic [31:0] got, exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s %h/%h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task complete_run;
      $display("checks %0d, errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task t_reset;
      cmp({28'h0, prediv}, 32'hf, "prediv");
      cmp(frame, 32'h0, "frame");
      cmp({31'h0, toe}, 32'h0, "oe");
      cmp({31'h0, act}, 32'h0, "active");
      interrupt_n_i <= 1'b0;
      tick(3);
      cmp({31'h0, pin}, 32'h0, "irq low");
      interrupt_n_i <= 1'b1;
      tick(3);
      cmp({31'h0, pin}, 32'h1, "irq high");
   endtask

   task t_write;
      int w;
      w = n_wr;
      interrupt_n_i <= 1'b0;
      cfw <= 1'b1;
      ref_l <= 3'h2;
      teq <= 3'h5;
      u_host.xfer({1'b0, 6'h0d, 1'b0, 24'h000123}, 32, HALF, rx);
      cmp(rx, {STAT, 24'h0}, "wr reply");
      cmp(u_host.rx_tri, {STAT, 24'h0}, "wr tri");
      cmp(last_frame, 32'h1a000123, "latch");
      cmp(32'(n_wr - w), 32'h1, "strobe");
   endtask

   // Register read with junk data, then a slow RAM read
   task t_read;
      int w;
      w = n_wr;
      u_host.xfer({1'b0, 6'h0d, 1'b1, 24'hffffff}, 32, HALF, rx);
      cmp(rx, {STAT, 1'b0, 6'h0d, 17'h0abcd}, "rd reg");
      u_host.xfer({1'b1, 6'h3f, 1'b1, 24'h0}, 32, 20, rx);
      cmp(rx, {STAT, 1'b1, 6'h3f, 17'h0abcd}, "rd ram");
      cmp(32'(n_wr - w), 32'h0, "no strobe");
   endtask

   task t_prediv;
      u_host.xfer({1'b0, 6'h3f, 1'b0, 24'h00000a}, 32, HALF, rx);
      cmp({28'h0, prediv}, 32'ha, "prediv set");
      u_host.xfer({1'b1, 6'h3f, 1'b0, 24'h000005}, 32, HALF, rx);
      cmp({28'h0, prediv}, 32'ha, "ram write");
   endtask

   task t_len;
      int f, e;
      f = n_fv;
      e = n_le;
      u_host.xfer(32'h7e000001, 31, HALF, rx);
      u_host.xfer(32'h7e000002, 33, HALF, rx);
      cmp(32'(n_le - e), 32'h2, "len err");
      cmp(32'(n_fv - f), 32'h0, "no latch");
   endtask

   task t_irq_only;
      irq_only_i <= 1'b1;
      interrupt_n_i <= 1'b0;
      u_host.xfer({1'b0, 6'h0d, 1'b1, 24'h0}, 32, HALF, rx);
      cmp(rx, 32'h0, "irq only");
      cmp(u_host.rx_tri, {STAT, 1'b0, 6'h0d, 17'h0abcd}, "tri");
      interrupt_n_i <= 1'b1;
      tick(3);
      cmp({31'h0, pin}, 32'h1, "irq only idle");
      irq_only_i <= 1'b0;
   endtask

   // Main sequence
   initial begin
      arst_n_i = 1'b0;
      irq_only_i = 1'b0;
      interrupt_n_i = 1'b1;
      cfw = 1'b0;
      ref_l = 3'h0;
      teq = 3'h0;
      tick(10);
      arst_n_i <= 1'b1;
      tick(10);
      t_reset;
      t_write;
      t_read;
      t_prediv;
      t_len;
      t_irq_only;
      complete_run;
   end
endmodule
`default_nettype wire
